// ==== shared/dspace_params.svh ====
// Address map, field positions and sizes of the data-space decoder.
`ifndef DSPACE_PARAMS_SVH
`define DSPACE_PARAMS_SVH

`define DS_BANK_LO        8'h00
`define DS_BANK_HI        8'h3F
`define DS_WIN_LO         8'h40
`define DS_WIN_HI         8'h7F
`define DS_CORE_LO        8'h80
`define DS_FIRST_PTR      8'h80
`define DS_SECOND_PTR     8'h81
`define DS_SHORT_A        8'h82
`define DS_SHORT_B        8'h83
`define DS_RAM_LO         8'h84
`define DS_CORE_HI        8'hBF
`define DS_PERIPH_LO      8'hC0
`define DS_WIN_BASE       8'hC9
`define DS_BANK_SEL       8'hE8
`define DS_ACC            8'hFF
`define DS_CORE_RAM_DEPTH 64
`define DS_WIN_OFS_W      6
`define DS_WIN_BASE_MSB   5
`define DS_BANK_RAM2_BIT  4
`define DS_BANK_EEP0_BIT  0
`define DS_WO_READ_VALUE  8'hFF
`define DS_DENIED_DATA    8'h00
`define DS_PC_W           12
`define DS_STACK_DEPTH    6

`endif

// ==== shared/dspace_pkg.sv ====
// Types shared by the data-space decoder and its return stack.
`include "dspace_params.svh"

package dspace_pkg;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_PM       = 5'b00010,
    ST_BANK     = 5'b00100,
    ST_PERIPH   = 5'b01000,
    ST_READOUT  = 5'b10000
  } seq_state_e;

  typedef enum logic [2:0] {
    RG_BANK     = 3'h0,
    RG_WINDOW   = 3'h1,
    RG_CORE     = 3'h2,
    RG_WIN_BASE = 3'h3,
    RG_BANK_SEL = 3'h4,
    RG_ACC      = 3'h5,
    RG_PERIPH   = 3'h6
  } region_e;

  // Classifies a data-space address into the region that answers it.
  function automatic region_e decode_region(input logic [7:0] addr);
    region_e r;
    r = RG_PERIPH;
    if (addr <= `DS_BANK_HI) begin
      r = RG_BANK;
    end else if (addr <= `DS_WIN_HI) begin
      r = RG_WINDOW;
    end else if (addr <= `DS_CORE_HI) begin
      r = RG_CORE;
    end else if (addr == `DS_WIN_BASE) begin
      r = RG_WIN_BASE;
    end else if (addr == `DS_BANK_SEL) begin
      r = RG_BANK_SEL;
    end else if (addr == `DS_ACC) begin
      r = RG_ACC;
    end
    return r;
  endfunction

endpackage

// ==== core/return_stack.sv ====
// Circular return-address stack; a push onto a full stack drops the oldest entry.
`timescale 1ns/1ps

module return_stack
  import dspace_pkg::*;
#(
  parameter int DEPTH = `DS_STACK_DEPTH,
  parameter int WIDTH = `DS_PC_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  output logic      [WIDTH-1:0] top_o,
  output logic                  empty_o,
  output logic                  full_o
);

  localparam int IW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [IW-1:0]    sp_q, sp_d;
  logic [IW:0]      cnt_q, cnt_d;

  // Index arithmetic that wraps at the stack depth.
  function automatic logic [IW-1:0] wrap_inc(input logic [IW-1:0] v);
    return (v == IW'(DEPTH - 1)) ? '0 : v + 1'b1;
  endfunction

  function automatic logic [IW-1:0] wrap_dec(input logic [IW-1:0] v);
    return (v == '0) ? IW'(DEPTH - 1) : v - 1'b1;
  endfunction

  // Next pointer and fill count; push wins if both arrive together.
  always_comb begin
    sp_d  = sp_q;
    cnt_d = cnt_q;
    if (push_i) begin
      sp_d = wrap_inc(sp_q);
      if (cnt_q != (IW+1)'(DEPTH)) begin
        cnt_d = cnt_q + 1'b1;
      end
    end else if (pop_i && cnt_q != '0) begin
      sp_d  = wrap_dec(sp_q);
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Six 12-bit return addresses held in flip-flops.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sp_q  <= '0;
      cnt_q <= '0;
    end else begin
      sp_q  <= sp_d;
      cnt_q <= cnt_d;
    end
    if (push_i && !srst_i) begin
      mem_q[sp_q] <= push_data_i;
    end
  end

  assign top_o   = mem_q[wrap_dec(sp_q)];
  assign empty_o = (cnt_q == '0);
  assign full_o  = (cnt_q == (IW+1)'(DEPTH));

endmodule

// ==== core/data_space_decode_rom_window.sv ====
// Data-space decoder with read-only program-memory window, core registers and RAM.
//
// Behaviour
// - Program memory addresses are 12 bits wide, 000h to FFFh.
// - Data addresses 40h..7Fh read program memory, never RAM.
// - Window address is window base bits above the six low data bits.
// - The window moves in 64-byte steps across program memory.
// - Window base sits write-only at C9h; reads are not supported.
// - Only bits 5..0 of the window base are kept.
// - Window base is not cleared by reset.
// - Data addresses 00h..3Fh go to the selected RAM or EEPROM bank.
// - Pointer registers at 80h, 81h; short-direct registers at 82h, 83h.
// - Sixty bytes of general RAM occupy 84h..BFh.
// - The accumulator is an ordinary data location at FFh.
// - A six-entry stack of 12-bit return addresses.
// - Readout protection blocks external reads of program memory.
// - Write-only bank select at E8h; bit 4 RAM page 2, bit 0 EEPROM.
`timescale 1ns/1ps

module data_space_decode_rom_window
  import dspace_pkg::*;
#(
  parameter int PC_W = `DS_PC_W
) (
  input  wire logic            core_clk_i,
  input  wire logic            srst_i,
  // Core data-space port.
  input  wire logic            dsp_rd_i,
  input  wire logic            dsp_wr_i,
  input  wire logic [7:0]      dsp_addr_i,
  input  wire logic [7:0]      dsp_wdata_i,
  output logic                 dsp_ready_o,
  output logic                 dsp_rvalid_o,
  output logic [7:0]           dsp_rdata_o,
  output logic [7:0]           acc_o,
  output logic [7:0]           first_pointer_o,
  output logic [7:0]           second_pointer_o,
  // Program memory port.
  output logic                 pm_rd_o,
  output logic [PC_W-1:0]      pm_addr_o,
  input  wire logic            pm_rvalid_i,
  input  wire logic [7:0]      pm_rdata_i,
  // Paged bank area (RAM page 2 or EEPROM page 0).
  output logic                 bank_ram2_sel_o,
  output logic                 bank_eep0_sel_o,
  output logic                 bank_rd_o,
  output logic                 bank_wr_o,
  output logic [5:0]           bank_addr_o,
  output logic [7:0]           bank_wdata_o,
  input  wire logic            bank_rvalid_i,
  input  wire logic [7:0]      bank_rdata_i,
  // Peripheral register area.
  output logic                 periph_rd_o,
  output logic                 periph_wr_o,
  output logic [7:0]           periph_addr_o,
  output logic [7:0]           periph_wdata_o,
  input  wire logic            periph_rvalid_i,
  input  wire logic [7:0]      periph_rdata_i,
  // External program-memory readout port.
  input  wire logic            readout_protect_i,
  input  wire logic            ext_rd_i,
  input  wire logic [PC_W-1:0] ext_addr_i,
  output logic                 ext_ready_o,
  output logic                 ext_rvalid_o,
  output logic                 ext_denied_o,
  output logic [7:0]           ext_rdata_o,
  // Return stack.
  input  wire logic            stack_push_i,
  input  wire logic            stack_pop_i,
  input  wire logic [PC_W-1:0] stack_push_data_i,
  output logic [PC_W-1:0]      stack_top_o,
  output logic                 stack_empty_o,
  output logic                 stack_full_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  seq_state_e      state_q, state_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            rvalid_q, rvalid_d;
  logic            pm_rd_q, pm_rd_d;
  logic [PC_W-1:0] pm_addr_q, pm_addr_d;
  logic            bank_rd_q, bank_rd_d;
  logic            bank_wr_q, bank_wr_d;
  logic [5:0]      bank_addr_q, bank_addr_d;
  logic [7:0]      bank_wdata_q, bank_wdata_d;
  logic            periph_rd_q, periph_rd_d;
  logic            periph_wr_q, periph_wr_d;
  logic [7:0]      periph_addr_q, periph_addr_d;
  logic [7:0]      periph_wdata_q, periph_wdata_d;
  logic [7:0]      ext_rdata_q, ext_rdata_d;
  logic            ext_rvalid_q, ext_rvalid_d;
  logic            ext_denied_q, ext_denied_d;

  logic [`DS_WIN_BASE_MSB:0] win_base_q, win_base_d;
  logic [7:0]                bank_sel_q, bank_sel_d;
  logic [7:0]                core_ram_q [`DS_CORE_RAM_DEPTH];
  logic [7:0]                acc_q, acc_d;
  logic                      core_ram_we;
  logic [5:0]                core_ram_idx;

  logic    protect_meta_q, protect_q;
  logic    rd_go, wr_go, ext_go;
  region_e req_region;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification.

  // The protection option is a pin level, so it is synchronised first.
  always_ff @(posedge core_clk_i) begin
    protect_meta_q <= readout_protect_i;
    protect_q      <= protect_meta_q;
  end

  // New requests are taken only while idle; the core has priority over readout.
  assign dsp_ready_o  = (state_q == ST_IDLE);
  assign ext_ready_o  = (state_q == ST_IDLE) && !dsp_rd_i && !dsp_wr_i;
  assign rd_go        = dsp_ready_o && dsp_rd_i;
  assign wr_go        = dsp_ready_o && dsp_wr_i && !dsp_rd_i;
  assign ext_go       = ext_ready_o && ext_rd_i;
  assign req_region   = decode_region(dsp_addr_i);
  assign core_ram_idx = dsp_addr_i[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Storage held by the decoder itself.

  // Next values of the window base, bank select, accumulator and core RAM write.
  always_comb begin
    win_base_d  = win_base_q;
    bank_sel_d  = bank_sel_q;
    acc_d       = acc_q;
    core_ram_we = 1'b0;
    if (wr_go) begin
      case (req_region)
        RG_WIN_BASE: begin
          win_base_d = dsp_wdata_i[`DS_WIN_BASE_MSB:0];
        end
        RG_BANK_SEL: begin
          bank_sel_d = dsp_wdata_i;
        end
        RG_ACC: begin
          acc_d = dsp_wdata_i;
        end
        RG_CORE: begin
          core_ram_we = 1'b1;
        end
        default: begin
          core_ram_we = 1'b0; // Window writes fall here and are dropped.
        end
      endcase
    end
  end

  // Window base and bank select have no reset term, so they survive reset.
  always_ff @(posedge core_clk_i) begin
    win_base_q <= win_base_d;
    bank_sel_q <= bank_sel_d;
    if (srst_i) begin
      acc_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
    end
    if (core_ram_we && !srst_i) begin
      core_ram_q[core_ram_idx] <= dsp_wdata_i;
    end
  end

  assign acc_o            = acc_q;
  assign first_pointer_o  = core_ram_q[6'(`DS_FIRST_PTR - `DS_CORE_LO)];
  assign second_pointer_o = core_ram_q[6'(`DS_SECOND_PTR - `DS_CORE_LO)];
  assign bank_ram2_sel_o  = bank_sel_q[`DS_BANK_RAM2_BIT];
  assign bank_eep0_sel_o  = bank_sel_q[`DS_BANK_EEP0_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  // Next state and registered outputs of the access sequencer.
  always_comb begin
    state_d        = state_q;
    rdata_d        = rdata_q;
    rvalid_d       = 1'b0;
    pm_rd_d        = 1'b0;
    pm_addr_d      = pm_addr_q;
    bank_rd_d      = 1'b0;
    bank_wr_d      = 1'b0;
    bank_addr_d    = bank_addr_q;
    bank_wdata_d   = bank_wdata_q;
    periph_rd_d    = 1'b0;
    periph_wr_d    = 1'b0;
    periph_addr_d  = periph_addr_q;
    periph_wdata_d = periph_wdata_q;
    ext_rdata_d    = ext_rdata_q;
    ext_rvalid_d   = 1'b0;
    ext_denied_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (rd_go) begin
          case (req_region)
            RG_WINDOW: begin
              pm_rd_d   = 1'b1;
              pm_addr_d = {win_base_q, dsp_addr_i[`DS_WIN_OFS_W-1:0]};
              state_d   = ST_PM;
            end
            RG_BANK: begin
              bank_rd_d   = 1'b1;
              bank_addr_d = dsp_addr_i[5:0];
              state_d     = ST_BANK;
            end
            RG_PERIPH: begin
              periph_rd_d   = 1'b1;
              periph_addr_d = dsp_addr_i;
              state_d       = ST_PERIPH;
            end
            RG_CORE: begin
              rdata_d  = core_ram_q[core_ram_idx];
              rvalid_d = 1'b1;
            end
            RG_ACC: begin
              rdata_d  = acc_q;
              rvalid_d = 1'b1;
            end
            default: begin
              rdata_d  = `DS_WO_READ_VALUE;
              rvalid_d = 1'b1;
            end
          endcase
        end else if (wr_go) begin
          if (req_region == RG_BANK) begin
            bank_wr_d    = 1'b1;
            bank_addr_d  = dsp_addr_i[5:0];
            bank_wdata_d = dsp_wdata_i;
          end else if (req_region == RG_PERIPH) begin
            periph_wr_d    = 1'b1;
            periph_addr_d  = dsp_addr_i;
            periph_wdata_d = dsp_wdata_i;
          end
        end else if (ext_go) begin
          if (protect_q) begin
            ext_rdata_d  = `DS_DENIED_DATA;
            ext_rvalid_d = 1'b1;
            ext_denied_d = 1'b1;
          end else begin
            pm_rd_d   = 1'b1;
            pm_addr_d = ext_addr_i;
            state_d   = ST_READOUT;
          end
        end
      end
      ST_PM: begin
        if (pm_rvalid_i) begin
          rdata_d  = pm_rdata_i;
          rvalid_d = 1'b1;
          state_d  = ST_IDLE;
        end
      end
      ST_BANK: begin
        if (bank_rvalid_i) begin
          rdata_d  = bank_rdata_i;
          rvalid_d = 1'b1;
          state_d  = ST_IDLE;
        end
      end
      ST_PERIPH: begin
        if (periph_rvalid_i) begin
          rdata_d  = periph_rdata_i;
          rvalid_d = 1'b1;
          state_d  = ST_IDLE;
        end
      end
      ST_READOUT: begin
        if (pm_rvalid_i) begin
          ext_rdata_d  = pm_rdata_i;
          ext_rvalid_d = 1'b1;
          state_d      = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers of the access sequencer.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q        <= ST_IDLE;
      rdata_q        <= 8'h00;
      rvalid_q       <= 1'b0;
      pm_rd_q        <= 1'b0;
      pm_addr_q      <= '0;
      bank_rd_q      <= 1'b0;
      bank_wr_q      <= 1'b0;
      bank_addr_q    <= 6'h00;
      bank_wdata_q   <= 8'h00;
      periph_rd_q    <= 1'b0;
      periph_wr_q    <= 1'b0;
      periph_addr_q  <= 8'h00;
      periph_wdata_q <= 8'h00;
      ext_rdata_q    <= 8'h00;
      ext_rvalid_q   <= 1'b0;
      ext_denied_q   <= 1'b0;
    end else begin
      state_q        <= state_d;
      rdata_q        <= rdata_d;
      rvalid_q       <= rvalid_d;
      pm_rd_q        <= pm_rd_d;
      pm_addr_q      <= pm_addr_d;
      bank_rd_q      <= bank_rd_d;
      bank_wr_q      <= bank_wr_d;
      bank_addr_q    <= bank_addr_d;
      bank_wdata_q   <= bank_wdata_d;
      periph_rd_q    <= periph_rd_d;
      periph_wr_q    <= periph_wr_d;
      periph_addr_q  <= periph_addr_d;
      periph_wdata_q <= periph_wdata_d;
      ext_rdata_q    <= ext_rdata_d;
      ext_rvalid_q   <= ext_rvalid_d;
      ext_denied_q   <= ext_denied_d;
    end
  end

  // Registered outputs.
  assign dsp_rvalid_o   = rvalid_q;
  assign dsp_rdata_o    = rdata_q;
  assign pm_rd_o        = pm_rd_q;
  assign pm_addr_o      = pm_addr_q;
  assign bank_rd_o      = bank_rd_q;
  assign bank_wr_o      = bank_wr_q;
  assign bank_addr_o    = bank_addr_q;
  assign bank_wdata_o   = bank_wdata_q;
  assign periph_rd_o    = periph_rd_q;
  assign periph_wr_o    = periph_wr_q;
  assign periph_addr_o  = periph_addr_q;
  assign periph_wdata_o = periph_wdata_q;
  assign ext_rdata_o    = ext_rdata_q;
  assign ext_rvalid_o   = ext_rvalid_q;
  assign ext_denied_o   = ext_denied_q;

  ////////////////////////////////////////////////////////////////////////////
  // Return stack.

  // Subroutine and interrupt return addresses.
  return_stack #(
    .DEPTH (`DS_STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_return_stack (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .push_i      (stack_push_i),
    .pop_i       (stack_pop_i),
    .push_data_i (stack_push_data_i),
    .top_o       (stack_top_o),
    .empty_o     (stack_empty_o),
    .full_o      (stack_full_o)
  );

endmodule

// ==== testbench/data_space_decode_rom_window_sva.sv ====
// Port checks of the data-space decoder.
`timescale 1ns/1ps

module data_space_checker #(
  parameter int PC_W = 12
) (
  input wire logic            core_clk_i,
  input wire logic            srst_i,
  input wire logic            dsp_rd_i,
  input wire logic            dsp_wr_i,
  input wire logic [7:0]      dsp_addr_i,
  input wire logic [7:0]      dsp_wdata_i,
  input wire logic            dsp_ready_o,
  input wire logic            dsp_rvalid_o,
  input wire logic [7:0]      dsp_rdata_o,
  input wire logic [7:0]      acc_o,
  input wire logic            pm_rd_o,
  input wire logic [PC_W-1:0] pm_addr_o,
  input wire logic            bank_ram2_sel_o,
  input wire logic            bank_eep0_sel_o,
  input wire logic            bank_rd_o,
  input wire logic            bank_wr_o,
  input wire logic [5:0]      bank_addr_o,
  input wire logic            periph_rd_o,
  input wire logic            periph_wr_o,
  input wire logic            ext_rvalid_o,
  input wire logic            ext_denied_o,
  input wire logic [7:0]      ext_rdata_o,
  input wire logic            stack_empty_o,
  input wire logic            stack_full_o
);
  logic       rd_tk, wr_tk, win;
  logic [5:0] base_q;
  logic       base_ok_q = 1'b0;

  // Requests taken this edge; a read wins over a write.
  assign rd_tk = dsp_rd_i && dsp_ready_o;
  assign wr_tk = dsp_wr_i && !dsp_rd_i && dsp_ready_o;
  assign win   = dsp_addr_i inside {[8'h40:8'h7F]};

  // Window base image; survives reset like the real one.
  always_ff @(posedge core_clk_i) begin
    if (wr_tk && dsp_addr_i == 8'hC9) begin
      base_q    <= dsp_wdata_i[5:0];
      base_ok_q <= 1'b1;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  //////////////////////////////////////////////////////////////////////
  a_window_pm_addr: assert property (rd_tk && win |=> pm_rd_o && pm_addr_o[5:0] == $past(dsp_addr_i[5:0])
    && !bank_rd_o && !periph_rd_o) else $error("window read misrouted");
  a_window_base_bits: assert property (rd_tk && win && base_ok_q |=> pm_addr_o[PC_W-1:6] == base_q)
    else $error("window base bits wrong");
  a_window_write_inert: assert property (wr_tk && win |=> !pm_rd_o && !bank_wr_o && !periph_wr_o)
    else $error("window write leaked");
  a_bank_route: assert property ((rd_tk || wr_tk) && dsp_addr_i <= 8'h3F |=> (bank_rd_o || bank_wr_o)
    && bank_addr_o == $past(dsp_addr_i[5:0])) else $error("bank misrouted");
  a_acc_write: assert property (wr_tk && dsp_addr_i == 8'hFF |=> acc_o == $past(dsp_wdata_i))
    else $error("acc not written");
  a_wo_read_filler: assert property (rd_tk && dsp_addr_i inside {8'hC9, 8'hE8} |=> dsp_rvalid_o
    && dsp_rdata_o == 8'hFF && !pm_rd_o) else $error("bad filler");
  a_bank_sel_out: assert property (wr_tk && dsp_addr_i == 8'hE8 |=> bank_ram2_sel_o == $past(dsp_wdata_i[4])
    && bank_eep0_sel_o == $past(dsp_wdata_i[0])) else $error("bank select wrong");
  a_core_ram_local: assert property (rd_tk && dsp_addr_i inside {[8'h80:8'hBF]} |=> dsp_rvalid_o
    && !pm_rd_o && !bank_rd_o && !periph_rd_o) else $error("core read not local");
  a_denied_empty: assert property (ext_denied_o |-> ext_rvalid_o && ext_rdata_o == 8'h00
    && !$past(pm_rd_o)) else $error("readout leaked");
  a_stack_flags: assert property (stack_full_o |-> !stack_empty_o) else $error("stack full and empty");

  // Main scenarios reached.
  c_window_read: cover property (rd_tk && win ##[1:8] dsp_rvalid_o);
  c_denied: cover property (ext_denied_o);
  c_stack_full: cover property (stack_full_o);
endmodule

bind data_space_decode_rom_window data_space_checker #(.PC_W(PC_W)) i_data_space_checker (.*);

// ==== testbench/far_side_model.sv ====
// Far-side responders of the decoder.
`timescale 1ns/1ps

module far_side_model #(
  parameter int PC_W = 12
) (
  input  wire logic            core_clk_i,
  input  wire logic            slow_i,
  input  wire logic            pm_rd_i,
  input  wire logic [PC_W-1:0] pm_addr_i,
  output logic                 pm_rvalid_o,
  output logic [7:0]           pm_rdata_o,
  input  wire logic            bank_rd_i,
  input  wire logic            bank_wr_i,
  input  wire logic [5:0]      bank_addr_i,
  input  wire logic [7:0]      bank_wdata_i,
  output logic                 bank_rvalid_o,
  output logic [7:0]           bank_rdata_o,
  input  wire logic            periph_rd_i,
  input  wire logic [7:0]      periph_addr_i,
  output logic                 periph_rvalid_o,
  output logic [7:0]           periph_rdata_o
);
  logic [7:0]      mem [64];
  logic [PC_W-1:0] pa_q;
  logic [1:0]      wait_q;
  logic            pend_q;

  // Program memory contents; each 64-byte block reads differently.
  function automatic logic [7:0] pm_byte(input logic [PC_W-1:0] a);
    return a[7:0] ^ {a[PC_W-1 -: 6], 2'b10};
  endfunction

  initial begin
    {pm_rvalid_o, bank_rvalid_o, periph_rvalid_o, pend_q} = 4'h0;
    {pm_rdata_o, bank_rdata_o, periph_rdata_o} = 24'h0;
  end

  // Answers promptly, program memory three edges late when slow; idle data lines flip every cycle.
  always @(posedge core_clk_i) begin
    {pm_rvalid_o, bank_rvalid_o, periph_rvalid_o} <= 3'h0;
    pm_rdata_o <= ~pm_rdata_o;
    bank_rdata_o <= ~bank_rdata_o;
    periph_rdata_o <= ~periph_rdata_o;
    if (pm_rd_i) begin
      pa_q <= pm_addr_i;
      pend_q <= 1'b1;
      wait_q <= slow_i ? 2'h3 : 2'h0;
    end else if (pend_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      pm_rvalid_o <= 1'b1;
      pm_rdata_o <= pm_byte(pa_q);
    end
    if (bank_wr_i) begin
      mem[bank_addr_i] <= bank_wdata_i;
    end
    if (bank_rd_i) begin
      bank_rvalid_o <= 1'b1;
      bank_rdata_o <= mem[bank_addr_i];
    end
    if (periph_rd_i) begin
      periph_rvalid_o <= 1'b1;
      periph_rdata_o <= ~periph_addr_i;
    end
  end
endmodule

// ==== testbench/data_space_decode_rom_window_tb_top.sv ====
// Self-checking testbench of the data-space decoder.
`timescale 1ns/1ps

module data_space_decode_rom_window_tb_top;
  import dspace_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        srst_i, dsp_rd_i, dsp_wr_i, dsp_ready_o, dsp_rvalid_o, pm_rd_o, pm_rvalid_i, slow;
  logic        bank_ram2_sel_o, bank_eep0_sel_o, bank_rd_o, bank_wr_o, bank_rvalid_i;
  logic        periph_rd_o, periph_wr_o, periph_rvalid_i, readout_protect_i, ext_rd_i;
  logic        ext_ready_o, ext_rvalid_o, ext_denied_o, stack_push_i, stack_pop_i, stack_empty_o, stack_full_o;
  logic [5:0]  bank_addr_o;
  logic [7:0]  dsp_addr_i, dsp_wdata_i, dsp_rdata_o, acc_o, first_pointer_o, second_pointer_o, pm_rdata_i;
  logic [7:0]  bank_wdata_o, bank_rdata_i, periph_addr_o, periph_wdata_o, periph_rdata_i, ext_rdata_o, win_img;
  logic [11:0] pm_addr_o, ext_addr_i, stack_push_data_i, stack_top_o;
  int          errors = 0;
  int          n_tests = 0;

  always #4 core_clk_i = ~core_clk_i;

  data_space_decode_rom_window i_data_space_decode_rom_window (.*);
  far_side_model i_far_side_model (.core_clk_i(core_clk_i), .slow_i(slow), .pm_rd_i(pm_rd_o),
    .pm_addr_i(pm_addr_o), .pm_rvalid_o(pm_rvalid_i), .pm_rdata_o(pm_rdata_i), .bank_rd_i(bank_rd_o),
    .bank_wr_i(bank_wr_o), .bank_addr_i(bank_addr_o), .bank_wdata_i(bank_wdata_o),
    .bank_rvalid_o(bank_rvalid_i), .bank_rdata_o(bank_rdata_i), .periph_rd_i(periph_rd_o),
    .periph_addr_i(periph_addr_o), .periph_rvalid_o(periph_rvalid_i), .periph_rdata_o(periph_rdata_i));

  //////////////////////////////////////////////////////////////////////
  // Expected program memory byte at a 12-bit address.
  function automatic logic [7:0] exp_pm(input logic [11:0] a);
    return a[7:0] ^ {a[11:6], 2'b10};
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Core write held one cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    do @(negedge core_clk_i); while (dsp_ready_o !== 1'b1);
    {dsp_wr_i, dsp_addr_i, dsp_wdata_i} = {1'b1, a, d};
    @(negedge core_clk_i);
    dsp_wr_i = 1'b0;
  endtask

  // Core read with bounded wait.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int k = 0;
    do @(negedge core_clk_i); while (dsp_ready_o !== 1'b1);
    {dsp_rd_i, dsp_addr_i} = {1'b1, a};
    @(negedge core_clk_i);
    dsp_rd_i = 1'b0;
    while (dsp_rvalid_o !== 1'b1 && k++ < 20) @(negedge core_clk_i);
    d = (dsp_rvalid_o === 1'b1) ? dsp_rdata_o : 8'hXX;
  endtask

  // External readout request and its answer.
  task automatic xrd(input logic [11:0] a, output logic [7:0] d, output logic den);
    int k = 0;
    do @(negedge core_clk_i); while (ext_ready_o !== 1'b1);
    {ext_rd_i, ext_addr_i} = {1'b1, a};
    @(negedge core_clk_i);
    ext_rd_i = 1'b0;
    while (ext_rvalid_o !== 1'b1 && k++ < 20) @(negedge core_clk_i);
    d = (ext_rvalid_o === 1'b1) ? ext_rdata_o : 8'hXX;
    den = ext_denied_o;
  endtask

  task automatic set_base(input logic [7:0] b);
    win_img = b;
    wr(8'hC9, b);
  endtask

  task automatic t_core_regs;
    logic [7:0] a [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hA0, 8'hBF, 8'hFF};
    logic [7:0] d;
    foreach (a[i]) wr(a[i], a[i] ^ 8'h96);
    foreach (a[i]) begin
      rd(a[i], d);
      chk(12'(d), 12'(a[i] ^ 8'h96));
    end
    chk(12'(first_pointer_o), 12'h016);
    chk(12'(second_pointer_o), 12'h017);
    chk(12'(acc_o), 12'h069);
  endtask

  // Base and offset extremes, the middle offset read slow for each base.
  task automatic t_window;
    logic [7:0] b [3] = '{8'h00, 8'hC5, 8'h3F};
    logic [7:0] o [3] = '{8'h40, 8'h45, 8'h7F};
    logic [7:0] d;
    foreach (b[i]) begin
      set_base(b[i]);
      foreach (o[j]) begin
        slow = (j == 1);
        rd(o[j], d);
        chk(12'(d), 12'(exp_pm({b[i][5:0], o[j][5:0]})));
      end
    end
    slow = 1'b0;
  endtask

  // Inert window writes and write-only reads.
  task automatic t_window_inert;
    logic [7:0] d;
    set_base(8'h12);
    wr(8'h47, 8'h00);
    rd(8'hC9, d);
    chk(12'(d), 12'h0FF);
    rd(8'hE8, d);
    chk(12'(d), 12'h0FF);
    rd(8'h47, d);
    chk(12'(d), 12'(exp_pm({win_img[5:0], 6'h07})));
    rd(8'hD0, d);
    chk(12'(d), 12'h02F);
  endtask

  task automatic t_bank;
    logic [7:0] d;
    wr(8'hE8, 8'h10);
    chk(12'({bank_ram2_sel_o, bank_eep0_sel_o}), 12'h002);
    wr(8'h00, 8'hAB);
    wr(8'h3F, 8'hCD);
    rd(8'h00, d);
    chk(12'(d), 12'h0AB);
    rd(8'h3F, d);
    chk(12'(d), 12'h0CD);
    wr(8'hE8, 8'h01);
    chk(12'({bank_ram2_sel_o, bank_eep0_sel_o}), 12'h001);
  endtask

  // The window base outlives a reset in mid-run.
  task automatic t_reset_keep;
    logic [7:0] d;
    set_base(8'h2A);
    srst_i = 1'b1;
    @(negedge core_clk_i);
    srst_i = 1'b0;
    chk(12'(acc_o), 12'h000);
    rd(8'h41, d);
    chk(12'(d), 12'(exp_pm({6'h2A, 6'h01})));
  endtask

  task automatic t_readout;
    logic [7:0] d;
    logic den;
    xrd(12'hFFF, d, den);
    chk({den, 3'h0, d}, 12'(exp_pm(12'hFFF)));
    readout_protect_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    xrd(12'hABC, d, den);
    chk({den, 3'h0, d}, 12'h800);
    readout_protect_i = 1'b0;
  endtask

  // Seven pushes into six places drop the oldest.
  task automatic t_stack;
    for (int i = 0; i < 7; i++) begin
      {stack_push_i, stack_push_data_i} = {1'b1, 12'h100 + 12'(i)};
      @(negedge core_clk_i);
    end
    stack_push_i = 1'b0;
    chk(12'(stack_full_o), 12'h001);
    for (int i = 6; i > 0; i--) begin
      chk(stack_top_o, 12'h100 + 12'(i));
      stack_pop_i = 1'b1;
      @(negedge core_clk_i);
      stack_pop_i = 1'b0;
    end
    chk(12'(stack_empty_o), 12'h001);
  endtask

  task automatic print_verdict;
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence after three cycles of reset.
  initial begin
    {srst_i, dsp_rd_i, dsp_wr_i, readout_protect_i, ext_rd_i, stack_push_i, stack_pop_i, slow} = 8'h80;
    {dsp_addr_i, dsp_wdata_i, win_img, ext_addr_i, stack_push_data_i} = 48'h0;
    repeat (3) @(negedge core_clk_i);
    srst_i = 1'b0;
    t_core_regs();
    t_window();
    t_window_inert();
    t_bank();
    t_reset_keep();
    t_readout();
    t_stack();
    print_verdict();
  end

  // Ends a hung run.
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
endmodule
